/* File: etls_defines.svh */
// Register offsets, field layouts and reset values for the torque limit select
`ifndef ETLS_DEFINES_SVH
`define ETLS_DEFINES_SVH
`define ETLS_OFS_FWD_INT_TRQ 6'h00
`define ETLS_OFS_REV_INT_TRQ 6'h04
`define ETLS_OFS_FWD_EXT_TRQ 6'h08
`define ETLS_OFS_REV_EXT_TRQ 6'h0C
`define ETLS_OFS_FWD_INT_FRC 6'h10
`define ETLS_OFS_REV_INT_FRC 6'h14
`define ETLS_OFS_CONFIG 6'h18
`define ETLS_OFS_STATUS 6'h1C
`define ETLS_OFS_FWD_LIMIT 6'h20
`define ETLS_OFS_REV_LIMIT 6'h24
`define ETLS_RST_INT_TRQ 16'h0320
`define ETLS_RST_EXT_TRQ 16'h0064
`define ETLS_RST_INT_FRC 16'h001E
`define ETLS_LIMIT_MAX 16'h0320
`define ETLS_RST_RATED_MAX 16'h0320
`define ETLS_CFG_LINEAR_BIT 0
`define ETLS_CFG_DIR_BIT 1
`define ETLS_CFG_FWD_SEL_LSB 4
`define ETLS_CFG_REV_SEL_LSB 8
`define ETLS_CFG_MAX_LSB 16
`define ETLS_RST_FWD_SEL 4'h0
`define ETLS_RST_REV_SEL 4'h1
`endif

/* File: etls_host_model.sv */
// Host controller model driving the limit request pins
module etls_host_model
(
  // Clock
  input wire logic clk,
  // Request levels and chosen pins
  input wire logic fwd_on,
  input wire logic rev_on,
  input wire logic [3:0] fwd_pin,
  input wire logic [3:0] rev_pin,
  // Digital input pins
  output logic [15:0] din
);
  logic [15:0] noise_ff = 16'h00FF;
  // ====================
  // Pin drive
  // Unused pins toggle so a wrong pin choice cannot pass by luck
  always_ff @(posedge clk)
  begin
    noise_ff <= {noise_ff[14:0], ~noise_ff[15]};
  end
  always_comb
  begin
    din = noise_ff;
    din[fwd_pin] = fwd_on;
    din[rev_pin] = rev_on;
  end
endmodule : etls_host_model

/* File: etls_pkg.sv */
// Types shared by the torque limit select block
package etls_pkg;
  typedef struct packed
  {
    logic [15:0] fwd;
    logic [15:0] rev;
  } etls_limit_pair_t;
  typedef struct packed
  {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [5:0] adr;
    logic [31:0] dat;
  } etls_wb_req_t;
endpackage : etls_pkg

/* File: etls_top.sv */
// Torque limit select with a classic Wishbone register slave
//
// Functional notes
// RQ1: Forward request on: min of forward internal, external
// RQ2: Forward request off: forward internal limit only
// RQ3: Reverse request on: min of reverse internal, external
// RQ4: Reverse request off: reverse internal limit only
// RQ5: Forward internal torque 0..800, default 800
// RQ6: Reverse internal torque 0..800, default 800
// RQ7: Forward external limit 0..800, default 100
// RQ8: Reverse external limit 0..800, default 100
// RQ9: Linear forward internal force, default 30
// RQ10: Linear reverse internal force, default 30
// RQ11: Lesser of external and internal, both motors
// RQ12: Internal torque limit ships at 800 percent
// RQ13: Direction digit zero: forward is counter-clockwise
// RQ14: Direction digit zero: linear forward counts up
// RQ15: Request inputs remappable to other input pins
// RQ16: Host avoids too small torque limits
// RQ17: Host avoids too small force limits
// RQ18: Clamp applied limit to maximum rated torque
// RQ19: Recompute every cycle, no request latching
`include "etls_defines.svh"
module etls_top
  import etls_pkg::*;
#(
  parameter int N_INPUTS = 16
)
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Wishbone slave
  input wire etls_pkg::etls_wb_req_t WB_REQ,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Digital input pins
  input wire logic [N_INPUTS-1:0] DIN,
  // Limits and direction flag to the current loop
  output etls_pkg::etls_limit_pair_t LIMIT,
  output logic CCW_IS_FWD
);
  import etls_pkg::*;
  // ==========================================================
  // Reset release
  logic rst_s1_ff;
  logic rst_n_ff;
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // ==========================================================
  // Input pin synchronisers
  logic [N_INPUTS-1:0] din_s1_ff;
  logic [N_INPUTS-1:0] din_ff;
  always_ff @(posedge CORE_CLK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      din_s1_ff <= '0;
      din_ff <= '0;
    end
    else
    begin
      din_s1_ff <= DIN;
      din_ff <= din_s1_ff;
    end
  end

  // ==========================================================
  // Parameter registers
  logic [15:0] fwd_int_trq_ff;
  logic [15:0] rev_int_trq_ff;
  logic [15:0] fwd_ext_trq_ff;
  logic [15:0] rev_ext_trq_ff;
  logic [15:0] fwd_int_frc_ff;
  logic [15:0] rev_int_frc_ff;
  logic linear_ff;
  logic dir_sel_ff;
  logic [3:0] fwd_sel_ff;
  logic [3:0] rev_sel_ff;
  logic [15:0] rated_max_ff;
  logic wr_en;
  logic [15:0] wr_val;
  logic ack_ff;

  assign wr_en = WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && !ack_ff
    && (&WB_REQ.sel[1:0]);
  // Values above the range are held at the top so a bad write stays legal
  assign wr_val = (WB_REQ.dat[15:0] > `ETLS_LIMIT_MAX)
    ? `ETLS_LIMIT_MAX : WB_REQ.dat[15:0];

  always_ff @(posedge CORE_CLK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      fwd_int_trq_ff <= `ETLS_RST_INT_TRQ; // [RQ5] [RQ12]
      rev_int_trq_ff <= `ETLS_RST_INT_TRQ; // [RQ6]
      fwd_ext_trq_ff <= `ETLS_RST_EXT_TRQ; // [RQ7]
      rev_ext_trq_ff <= `ETLS_RST_EXT_TRQ; // [RQ8]
      fwd_int_frc_ff <= `ETLS_RST_INT_FRC; // [RQ9]
      rev_int_frc_ff <= `ETLS_RST_INT_FRC; // [RQ10]
    end
    else if (wr_en)
    begin
      unique case (WB_REQ.adr)
        `ETLS_OFS_FWD_INT_TRQ: fwd_int_trq_ff <= wr_val; // [RQ5]
        `ETLS_OFS_REV_INT_TRQ: rev_int_trq_ff <= wr_val; // [RQ6]
        `ETLS_OFS_FWD_EXT_TRQ: fwd_ext_trq_ff <= wr_val; // [RQ7]
        `ETLS_OFS_REV_EXT_TRQ: rev_ext_trq_ff <= wr_val; // [RQ8]
        `ETLS_OFS_FWD_INT_FRC: fwd_int_frc_ff <= wr_val; // [RQ9]
        `ETLS_OFS_REV_INT_FRC: rev_int_frc_ff <= wr_val; // [RQ10]
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      linear_ff <= 1'b0;
      dir_sel_ff <= 1'b0;
      fwd_sel_ff <= `ETLS_RST_FWD_SEL;
      rev_sel_ff <= `ETLS_RST_REV_SEL;
      rated_max_ff <= `ETLS_RST_RATED_MAX;
    end
    else if (wr_en && WB_REQ.adr == `ETLS_OFS_CONFIG
      && (&WB_REQ.sel))
    begin
      linear_ff <= WB_REQ.dat[`ETLS_CFG_LINEAR_BIT];
      dir_sel_ff <= WB_REQ.dat[`ETLS_CFG_DIR_BIT];
      fwd_sel_ff <= WB_REQ.dat[`ETLS_CFG_FWD_SEL_LSB +: 4]; // [RQ15]
      rev_sel_ff <= WB_REQ.dat[`ETLS_CFG_REV_SEL_LSB +: 4]; // [RQ15]
      rated_max_ff <= WB_REQ.dat[`ETLS_CFG_MAX_LSB +: 16];
    end
  end

  // ==========================================================
  // Limit selection, recomputed every cycle
  logic fwd_req;
  logic rev_req;
  logic [15:0] fwd_int;
  logic [15:0] rev_int;
  logic [15:0] nxt_fwd;
  logic [15:0] nxt_rev;
  logic [15:0] fwd_sel_val;
  logic [15:0] rev_sel_val;

  // Selector bits above the pin count are dropped, so a large value wraps onto a lower pin
  assign fwd_req = din_ff[fwd_sel_ff[$clog2(N_INPUTS)-1:0]]; // [RQ15] [RQ19]
  assign rev_req = din_ff[rev_sel_ff[$clog2(N_INPUTS)-1:0]]; // [RQ15] [RQ19]
  assign fwd_int = linear_ff ? fwd_int_frc_ff : fwd_int_trq_ff; // [RQ9]
  assign rev_int = linear_ff ? rev_int_frc_ff : rev_int_trq_ff; // [RQ10]

  always_comb
  begin
    fwd_sel_val = fwd_int; // [RQ2]
    if (fwd_req && fwd_ext_trq_ff < fwd_int)
      fwd_sel_val = fwd_ext_trq_ff; // [RQ1] [RQ11]
    rev_sel_val = rev_int; // [RQ4]
    if (rev_req && rev_ext_trq_ff < rev_int)
      rev_sel_val = rev_ext_trq_ff; // [RQ3] [RQ11]
    nxt_fwd = (fwd_sel_val > rated_max_ff) ? rated_max_ff : fwd_sel_val; // [RQ18]
    nxt_rev = (rev_sel_val > rated_max_ff) ? rated_max_ff : rev_sel_val; // [RQ18]
  end

  etls_limit_pair_t limit_ff;
  logic ccw_ff;
  always_ff @(posedge CORE_CLK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      limit_ff <= '0;
      ccw_ff <= 1'b1;
    end
    else
    begin
      limit_ff.fwd <= nxt_fwd; // [RQ19]
      limit_ff.rev <= nxt_rev; // [RQ19]
      // Digit zero: forward is CCW, or count-up on a linear motor
      ccw_ff <= !dir_sel_ff; // [RQ13] [RQ14]
    end
  end
  assign LIMIT = limit_ff;
  assign CCW_IS_FWD = ccw_ff;

  // ==========================================================
  // Wishbone read and acknowledge, registered ack one cycle after the request
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;
  always_comb
  begin
    nxt_rd = 32'h00000000;
    unique case (WB_REQ.adr)
      `ETLS_OFS_FWD_INT_TRQ: nxt_rd = {16'h0000, fwd_int_trq_ff};
      `ETLS_OFS_REV_INT_TRQ: nxt_rd = {16'h0000, rev_int_trq_ff};
      `ETLS_OFS_FWD_EXT_TRQ: nxt_rd = {16'h0000, fwd_ext_trq_ff};
      `ETLS_OFS_REV_EXT_TRQ: nxt_rd = {16'h0000, rev_ext_trq_ff};
      `ETLS_OFS_FWD_INT_FRC: nxt_rd = {16'h0000, fwd_int_frc_ff};
      `ETLS_OFS_REV_INT_FRC: nxt_rd = {16'h0000, rev_int_frc_ff};
      `ETLS_OFS_CONFIG: nxt_rd = {rated_max_ff, 4'h0, rev_sel_ff,
        fwd_sel_ff, 2'b00, dir_sel_ff, linear_ff};
      `ETLS_OFS_STATUS: nxt_rd = {30'h0, rev_req, fwd_req};
      `ETLS_OFS_FWD_LIMIT: nxt_rd = {16'h0000, limit_ff.fwd};
      `ETLS_OFS_REV_LIMIT: nxt_rd = {16'h0000, limit_ff.rev};
      default: nxt_rd = 32'h00000000;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      ack_ff <= 1'b0;
      rd_ff <= 32'h00000000;
    end
    else
    begin
      // Ack drops after one cycle so a held request is not taken twice
      ack_ff <= WB_REQ.cyc && WB_REQ.stb && !ack_ff;
      rd_ff <= nxt_rd;
    end
  end
  assign WB_DAT_O = rd_ff;
  assign WB_ACK_O = ack_ff;

  // ==========================================================
  // Checks
  // Held off one edge past reset: LIMIT still shows zero then
  logic chk_en_ff;
  always_ff @(posedge CORE_CLK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      chk_en_ff <= 1'b0;
    else
      chk_en_ff <= 1'b1;
  end

  property p_fwd_on;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    fwd_req && fwd_ext_trq_ff <= fwd_int && fwd_ext_trq_ff <= rated_max_ff
      |=> LIMIT.fwd == $past(fwd_ext_trq_ff);
  endproperty
  a_fwd_on: assert property (p_fwd_on) // [RQ1]
    else $error("Forward limit not external minimum");
  property p_fwd_off;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    !fwd_req && fwd_int <= rated_max_ff |=> LIMIT.fwd == $past(fwd_int);
  endproperty
  a_fwd_off: assert property (p_fwd_off) // [RQ2]
    else $error("Forward limit not internal value");
  property p_rev_on;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    rev_req && rev_ext_trq_ff <= rev_int && rev_ext_trq_ff <= rated_max_ff
      |=> LIMIT.rev == $past(rev_ext_trq_ff);
  endproperty
  a_rev_on: assert property (p_rev_on) // [RQ3]
    else $error("Reverse limit not external minimum");
  property p_rev_off;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    !rev_req && rev_int <= rated_max_ff |=> LIMIT.rev == $past(rev_int);
  endproperty
  a_rev_off: assert property (p_rev_off) // [RQ4]
    else $error("Reverse limit not internal value");
  property p_min;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    ##1 LIMIT.fwd <= $past(fwd_int) && LIMIT.rev <= $past(rev_int);
  endproperty
  a_min: assert property (p_min) // [RQ11]
    else $error("Limit above internal value");
  property p_clamp;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    ##1 LIMIT.fwd <= $past(rated_max_ff) && LIMIT.rev <= $past(rated_max_ff);
  endproperty
  a_clamp: assert property (p_clamp) // [RQ18]
    else $error("Limit above rated maximum");
  property p_range;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    fwd_int_trq_ff <= `ETLS_LIMIT_MAX && rev_int_trq_ff <= `ETLS_LIMIT_MAX
      && fwd_ext_trq_ff <= `ETLS_LIMIT_MAX;
  endproperty
  a_range: assert property (p_range) // [RQ5]
    else $error("Parameter beyond range");
  property p_frc_range;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    rev_ext_trq_ff <= `ETLS_LIMIT_MAX && fwd_int_frc_ff <= `ETLS_LIMIT_MAX
      && rev_int_frc_ff <= `ETLS_LIMIT_MAX;
  endproperty
  a_frc_range: assert property (p_frc_range) // [RQ8]
    else $error("Force or external parameter beyond range");
  property p_write;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    wr_en && WB_REQ.adr == `ETLS_OFS_REV_EXT_TRQ
      |=> rev_ext_trq_ff == $past(wr_val);
  endproperty
  a_write: assert property (p_write) // [RQ8]
    else $error("Reverse external write lost");
  property p_lin_fwd;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    linear_ff && !fwd_req && fwd_int_frc_ff <= rated_max_ff
      |=> LIMIT.fwd == $past(fwd_int_frc_ff);
  endproperty
  a_lin_fwd: assert property (p_lin_fwd) // [RQ9]
    else $error("Forward force limit not used");
  property p_lin_rev;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    linear_ff && !rev_req && rev_int_frc_ff <= rated_max_ff
      |=> LIMIT.rev == $past(rev_int_frc_ff);
  endproperty
  a_lin_rev: assert property (p_lin_rev) // [RQ10]
    else $error("Reverse force limit not used");
  property p_ccw;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    ##1 CCW_IS_FWD == !$past(dir_sel_ff);
  endproperty
  a_ccw: assert property (p_ccw) // [RQ13]
    else $error("Direction flag wrong");
  property p_remap;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    wr_en && WB_REQ.adr == `ETLS_OFS_CONFIG && (&WB_REQ.sel)
      |=> fwd_sel_ff == $past(WB_REQ.dat[`ETLS_CFG_FWD_SEL_LSB +: 4])
      && rev_sel_ff == $past(WB_REQ.dat[`ETLS_CFG_REV_SEL_LSB +: 4]);
  endproperty
  a_remap: assert property (p_remap) // [RQ15]
    else $error("Request pin choice lost");
  property p_ack;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack)
    else $error("Ack held two cycles");
  property p_ack_take;
    @(posedge CORE_CLK) disable iff (!chk_en_ff)
    WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack_take: assert property (p_ack_take)
    else $error("Request not acknowledged");
endmodule : etls_top

/* File: tb.sv */
// Random and corner tests of the torque limit select
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import etls_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  etls_wb_req_t wb = '0;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] din;
  etls_limit_pair_t lim;
  logic ccw;
  logic f_on = 1'b0;
  logic r_on = 1'b0;
  logic [3:0] f_pin = 4'h0;
  logic [3:0] r_pin = 4'h1;
  int mismatches = 0;
  int samples_checked = 0;
  logic [15:0] lf = 16'h0040;
  logic [15:0] m [0:5];
  logic lin = 1'b0;
  logic dir = 1'b0;
  logic [15:0] rmax = 16'h0320;
  etls_top i_etls_top (.CORE_CLK(clk), .RESETN(rst_n), .WB_REQ(wb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .DIN(din), .LIMIT(lim),
    .CCW_IS_FWD(ccw));
  etls_host_model i_etls_host_model (.clk(clk), .fwd_on(f_on),
    .rev_on(r_on), .fwd_pin(f_pin), .rev_pin(r_pin), .din(din));
  initial
  begin
    forever #20 clk = ~clk;
  end
  // ====================
  // Helpers
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd
  function automatic logic [15:0] pick(logic [15:0] a, logic [15:0] b);
    return (a < b) ? a : b;
  endfunction : pick
  function automatic logic [31:0] exp_lim();
    logic [15:0] fi;
    logic [15:0] ri;
    logic [15:0] f;
    logic [15:0] r;
    fi = lin ? m[4] : m[0];
    ri = lin ? m[5] : m[1];
    f = f_on ? pick(fi, m[2]) : fi;
    r = r_on ? pick(ri, m[3]) : ri;
    return {pick(f, rmax), pick(r, rmax)};
  endfunction : exp_lim
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wb <= '{1'b1, 1'b1, w, 4'hF, a, d};
    // Waits for ack however long; only the watchdog ends a hang
    do
    begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    wb <= '0;
  endtask : bus
  task automatic chk_lim();
    repeat (4) @(posedge clk);
    chk("limit", exp_lim(), lim);
  endtask : chk_lim
  task automatic summarize();
    $display("Checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  // ====================
  // Main sequence
  initial
  begin
    logic [31:0] q;
    logic [15:0] v;
    logic [31:0] e;
    int i;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 6; i++)
    begin
      m[i] = (i < 2) ? 16'h0320 : (i < 4) ? 16'h0064 : 16'h001E;
      bus(1'b0, 6'(i * 4), '0, q);
      chk("reg", {16'h0, m[i]}, q);
    end
    bus(1'b0, 6'h18, '0, q);
    chk("config", 32'h03200100, q);
    bus(1'b0, 6'h28, '0, q);
    chk("unmapped", 32'h0, q);
    chk("ccw", 32'h1, {31'h0, ccw});
    chk_lim();
    for (int k = 0; k < 64; k++)
    begin
      v = rnd();
      if (k % 8 == 0)
      begin
        lin = k[3];
        dir = k[4];
        rmax = k[5] ? 16'h00C8 : 16'h0320;
        f_pin <= v[3:0];
        r_pin <= ~v[3:0];
        bus(1'b1, 6'h18, {rmax, 4'h0, ~v[3:0], v[3:0], 2'b0, dir, lin},
          q);
        repeat (2) @(posedge clk);
        chk("ccw", {31'h0, ~dir}, {31'h0, ccw});
      end
      // Mostly sensible sizes, plus zero, 800 and over-range
      case (k % 7)
        0: v = 16'h0321 + v[3:0];
        1: v = 16'h0320;
        2: v = 16'h0000;
        default: v = 16'h000A + v % 16'd791;
      endcase
      bus(1'b1, 6'((k % 6) * 4), {16'h0, v}, q);
      m[k % 6] = pick(v, 16'h0320);
      bus(1'b0, 6'((k % 6) * 4), '0, q);
      chk("reg", {16'h0, m[k % 6]}, q);
      v = rnd();
      f_on <= v[4];
      r_on <= v[9];
      chk_lim();
      e = exp_lim();
      bus(1'b0, 6'h20, '0, q);
      chk("fwd_applied", {16'h0, e[31:16]}, q);
      bus(1'b0, 6'h24, '0, q);
      chk("rev_applied", {16'h0, e[15:0]}, q);
      bus(1'b0, 6'h1C, '0, q);
      chk("status", {30'h0, r_on, f_on}, q);
    end
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : tb
